/* File: src/dee_pkg.sv */
package dee_pkg;

  // Register select codes on the SFR port
  localparam int SEL_W = 3;
  localparam logic [2:0] SEL_CONTROL = 3'h0;
  localparam logic [2:0] SEL_UNLOCK = 3'h1;
  localparam logic [2:0] SEL_DATA = 3'h2;
  localparam logic [2:0] SEL_ADDR = 3'h3;
  localparam logic [2:0] SEL_PFLAG2 = 3'h4;

  // Control register field positions, then the PFLAG2 done bit
  localparam int CTL_RD = 0;
  localparam int CTL_WR = 1;
  localparam int CTL_WRITE_PERMIT = 2;
  localparam int CTL_WRITE_ERROR_FLAG = 3;
  localparam int CTL_FREE = 4;
  localparam int CTL_UNIMPL = 5;
  localparam int CTL_CONFIG_SPACE_SELECT = 6;
  localparam int CTL_MSEL = 7;
  localparam int PF2_DONE = 4;

  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Timing, in ns; counts derived at the clock period
  localparam int CLK_PERIOD_NS = 4;
  localparam int WRITE_TIME_NS = 4000000;
  localparam int PWRT_TIME_NS = 1000000;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int PWRT_CYCLES = PWRT_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    DEE_LOCK_IDLE = 2'b00,
    DEE_LOCK_GOT55 = 2'b01,
    DEE_LOCK_ARMED = 2'b10
  } dee_lock_t;

  function automatic logic dee_hit(input logic strobe, input logic [2:0] sel,
                                   input logic [2:0] code);
    dee_hit = strobe && (sel == code);
  endfunction

endpackage

/* File: src/dee_array.sv */
module dee_array #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);
  localparam int DEPTH = 1 << ADDR_W;

  logic [DATA_W-1:0] mem [DEPTH];

  // Nonvolatile contents: no reset
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_word
      logic [DATA_W-1:0] next_word;
      always_comb begin
        next_word = mem[i];
        if (wr_en && (wr_addr == ADDR_W'(i))) begin
          next_word = wr_data;
        end
      end
      always_ff @(posedge mclk) begin
        mem[i] <= next_word;
      end
    end
  endgenerate

  assign rd_data = mem[rd_addr];
endmodule

/* File: src/dee_top.sv */
module dee_top #(
  parameter int ADDR_W = 8,
  parameter int WRITE_CYCLES = dee_pkg::WRITE_CYCLES,
  parameter int PWRT_CYCLES = dee_pkg::PWRT_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic power_on_rst,
  input wire logic [dee_pkg::SEL_W-1:0] sfr_sel,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic eeprom_done_flag,
  output logic nvm_busy,
  output logic flash_op_active
);
  import dee_pkg::*;

  // Address register is one byte at most
  if (ADDR_W < 1 || ADDR_W > 8) begin : g_bad_addr_w
    $error("ADDR_W must be 1..8");
  end
  if (WRITE_CYCLES < 2) begin : g_bad_write_cycles
    $error("WRITE_CYCLES must be at least 2");
  end
  if (PWRT_CYCLES < 0) begin : g_bad_pwrt_cycles
    $error("PWRT_CYCLES must not be negative");
  end

  logic memory_space_select, config_space_select, row_erase, write_error_flag;
  logic write_permit, wr_start, rd_start, done;
  logic next_memory_space_select, next_config_space_select, next_row_erase;
  logic next_write_error_flag, next_write_permit, next_wr_start, next_rd_start, next_done;
  logic [7:0] nvm_data_reg, next_nvm_data_reg;
  logic [ADDR_W-1:0] nvm_address_reg, next_nvm_address_reg;
  logic [7:0] rdata, next_rdata;
  // Wide enough for any int cycle count
  logic [31:0] wcnt, next_wcnt;
  logic [31:0] pwrt_cnt, next_pwrt_cnt;
  dee_lock_t lock, next_lock;
  logic arr_we;
  logic [7:0] arr_wdata, arr_rd_data;
  logic ctl_wr, unl_wr, dat_wr, adr_wr, pf2_wr;
  logic eeprom_target, last_cycle;

  dee_array #(.ADDR_W(ADDR_W), .DATA_W(8)) u_array (
    .mclk(mclk),
    .wr_en(arr_we),
    .wr_addr(nvm_address_reg),
    .wr_data(arr_wdata),
    .rd_addr(nvm_address_reg),
    .rd_data(arr_rd_data)
  );

  assign ctl_wr = dee_hit(sfr_wr, sfr_sel, SEL_CONTROL);
  assign unl_wr = dee_hit(sfr_wr, sfr_sel, SEL_UNLOCK);
  assign dat_wr = dee_hit(sfr_wr, sfr_sel, SEL_DATA);
  assign adr_wr = dee_hit(sfr_wr, sfr_sel, SEL_ADDR);
  assign pf2_wr = dee_hit(sfr_wr, sfr_sel, SEL_PFLAG2);
  assign eeprom_target = !memory_space_select && !config_space_select;
  assign last_cycle = wr_start && (wcnt == 32'd1);

  always_comb begin
    next_memory_space_select = memory_space_select;
    next_config_space_select = config_space_select;
    next_row_erase = row_erase;
    next_write_error_flag = write_error_flag;
    next_write_permit = write_permit;
    next_wr_start = wr_start;
    next_rd_start = 1'b0;
    next_done = done;
    next_nvm_data_reg = nvm_data_reg;
    next_nvm_address_reg = nvm_address_reg;
    next_wcnt = wcnt;
    next_pwrt_cnt = (pwrt_cnt != 32'd0) ? pwrt_cnt - 32'd1 : 32'd0;
    next_lock = lock;
    arr_we = 1'b0;
    arr_wdata = nvm_data_reg;
    next_rdata = BYTE_ZERO;

    // Any write off the exact sequence drops the unlock
    if (sfr_wr) begin
      case (lock)
        DEE_LOCK_IDLE: begin
          next_lock = (unl_wr && sfr_wdata == UNLOCK_KEY1) ? DEE_LOCK_GOT55 : DEE_LOCK_IDLE;
        end
        DEE_LOCK_GOT55: begin
          next_lock = (unl_wr && sfr_wdata == UNLOCK_KEY2) ? DEE_LOCK_ARMED : DEE_LOCK_IDLE;
        end
        DEE_LOCK_ARMED: begin
          next_lock = DEE_LOCK_IDLE;
        end
        default: begin
          next_lock = DEE_LOCK_IDLE;
        end
      endcase
    end

    // Software may clear the done flag; completion below wins
    if (pf2_wr) begin
      next_done = sfr_wdata[PF2_DONE];
    end

    if (wr_start) begin
      if (last_cycle) begin
        next_wr_start = 1'b0;
        next_write_error_flag = 1'b0;
        next_row_erase = 1'b0;
        next_done = 1'b1;
        arr_we = eeprom_target;
      end else begin
        next_wcnt = wcnt - 32'd1;
      end
    end else begin
      if (ctl_wr) begin
        next_memory_space_select = sfr_wdata[CTL_MSEL];
        next_config_space_select = sfr_wdata[CTL_CONFIG_SPACE_SELECT];
        next_row_erase = sfr_wdata[CTL_FREE];
        next_write_error_flag = sfr_wdata[CTL_WRITE_ERROR_FLAG];
        next_write_permit = sfr_wdata[CTL_WRITE_PERMIT];
        if (sfr_wdata[CTL_WR]) begin
          // Permit must predate this write; same-write set does not count
          if (lock == DEE_LOCK_ARMED && write_permit && pwrt_cnt == 32'd0) begin
            next_wr_start = 1'b1;
            next_wcnt = 32'(WRITE_CYCLES);
            if (!sfr_wdata[CTL_MSEL] && !sfr_wdata[CTL_CONFIG_SPACE_SELECT]) begin
              arr_we = 1'b1;
              arr_wdata = ERASED_BYTE;
            end
          end else begin
            next_write_error_flag = 1'b1;
          end
        end
        if (sfr_wdata[CTL_RD] && !sfr_wdata[CTL_MSEL] && !sfr_wdata[CTL_CONFIG_SPACE_SELECT]) begin
          next_rd_start = 1'b1;
          next_nvm_data_reg = arr_rd_data;
        end
      end
      if (dat_wr) begin
        next_nvm_data_reg = sfr_wdata;
      end
      if (adr_wr) begin
        next_nvm_address_reg = sfr_wdata[ADDR_W-1:0];
      end
    end

    if (sfr_rd) begin
      case (sfr_sel)
        SEL_CONTROL: begin
          next_rdata = {memory_space_select, config_space_select, 1'b0, row_erase,
                        write_error_flag, write_permit, wr_start, rd_start};
        end
        SEL_DATA: next_rdata = nvm_data_reg;
        SEL_ADDR: next_rdata = 8'(nvm_address_reg);
        SEL_PFLAG2: next_rdata = 8'(done) << PF2_DONE;
        default: next_rdata = BYTE_ZERO;
      endcase
    end

    // Sync reset; warm reset keeps selects and records an aborted write
    if (!rstn) begin
      arr_we = 1'b0;
      next_row_erase = 1'b0;
      next_write_permit = 1'b0;
      next_wr_start = 1'b0;
      next_rd_start = 1'b0;
      next_done = 1'b0;
      next_lock = DEE_LOCK_IDLE;
      next_wcnt = 32'd0;
      next_rdata = BYTE_ZERO;
      next_nvm_data_reg = BYTE_ZERO;
      next_nvm_address_reg = '0;
      if (power_on_rst) begin
        next_memory_space_select = 1'b0;
        next_config_space_select = 1'b0;
        next_write_error_flag = 1'b0;
        next_pwrt_cnt = 32'(PWRT_CYCLES);
      end else begin
        next_write_error_flag = write_error_flag | wr_start;
      end
    end
  end

  always_ff @(posedge mclk) begin
    memory_space_select <= next_memory_space_select;
    config_space_select <= next_config_space_select;
    row_erase <= next_row_erase;
    write_error_flag <= next_write_error_flag;
    write_permit <= next_write_permit;
    wr_start <= next_wr_start;
    rd_start <= next_rd_start;
    done <= next_done;
    nvm_data_reg <= next_nvm_data_reg;
    nvm_address_reg <= next_nvm_address_reg;
    rdata <= next_rdata;
    wcnt <= next_wcnt;
    pwrt_cnt <= next_pwrt_cnt;
    lock <= next_lock;
  end

  assign sfr_rdata = rdata;
  assign eeprom_done_flag = done;
  assign nvm_busy = wr_start;
  assign flash_op_active = wr_start && !eeprom_target;

  default clocking cb @(posedge mclk); endclocking

  // Register bus and read path

  a_unimpl_zero: assert property (disable iff (!rstn)
    (sfr_rd && sfr_sel == SEL_CONTROL) |=> !sfr_rdata[CTL_UNIMPL])
    else $error("control bit 5 read nonzero");
  a_unlock_zero: assert property (disable iff (!rstn)
    (sfr_rd && sfr_sel == SEL_UNLOCK) |=> (sfr_rdata == BYTE_ZERO))
    else $error("unlock port read nonzero");
  a_addr_read: assert property (disable iff (!rstn)
    (sfr_rd && sfr_sel == SEL_ADDR) |=> (sfr_rdata == 8'($past(nvm_address_reg))))
    else $error("address register read back wrong");
  a_read_blocked: assert property (disable iff (!rstn)
    (ctl_wr && !wr_start && (sfr_wdata[CTL_MSEL] || sfr_wdata[CTL_CONFIG_SPACE_SELECT])) |=> !rd_start)
    else $error("read started outside data EEPROM space");

  // Write sequencing and read start
  a_start_unlocked: assert property (disable iff (!rstn)
    $rose(wr_start) |-> ($past(lock) == DEE_LOCK_ARMED))
    else $error("write started without unlock sequence");
  a_start_permit: assert property (disable iff (!rstn)
    $rose(wr_start) |-> ($past(write_permit) && $past(pwrt_cnt) == 32'd0))
    else $error("write started without earlier permit or in power-up time");
  a_read_pulse: assert property (disable iff (!rstn)
    rd_start |=> !rd_start)
    else $error("read start held more than one cycle");
  a_read_data: assert property (disable iff (!rstn)
    (ctl_wr && !wr_start && sfr_wdata[CTL_RD] && !sfr_wdata[CTL_MSEL] &&
     !sfr_wdata[CTL_CONFIG_SPACE_SELECT]) |=> (rd_start && nvm_data_reg == $past(arr_rd_data)))
    else $error("read byte not in data register next cycle");
  a_busy_frozen: assert property (disable iff (!rstn)
    (wr_start && !last_cycle) |=> ($stable(nvm_data_reg) && $stable(nvm_address_reg) &&
                                   $stable(memory_space_select) && $stable(write_permit)))
    else $error("register changed during write");
  a_write_time: assert property (disable iff (!rstn)
    $rose(wr_start) |-> (wcnt == 32'(WRITE_CYCLES)))
    else $error("write timer not loaded");
  a_done_sets: assert property (disable iff (!rstn)
    last_cycle |=> (!wr_start && done && !row_erase && !write_error_flag))
    else $error("completion did not clear start and set done");
  a_array_commit: assert property (disable iff (!rstn)
    (last_cycle && eeprom_target) |=> (arr_rd_data == $past(nvm_data_reg)))
    else $error("array not updated at completion");
  a_erase_first: assert property (disable iff (!rstn)
    ($rose(wr_start) && eeprom_target) |-> (arr_rd_data == ERASED_BYTE))
    else $error("location not erased at write start");
  a_done_hold: assert property (disable iff (!rstn)
    (done && !pf2_wr) |=> done)
    else $error("done flag cleared without software");
  a_wr_hold: assert property (disable iff (!rstn)
    (wr_start && !last_cycle) |=> wr_start)
    else $error("write start cleared before completion");
  a_error_on_refuse: assert property (disable iff (!rstn)
    (ctl_wr && !wr_start && sfr_wdata[CTL_WR] && (lock != DEE_LOCK_ARMED || !write_permit))
    |=> (write_error_flag && !wr_start))
    else $error("refused write start not flagged");
  a_flash_no_commit: assert property (disable iff (!rstn)
    (last_cycle && !eeprom_target) |=> $stable(arr_rd_data))
    else $error("flash operation changed the data array");
  a_pwrt_block: assert property (disable iff (!rstn)
    (pwrt_cnt != 32'd0) |=> !$rose(wr_start))
    else $error("write started during power-up time");

  // Reset behaviour
  a_reset_error: assert property (
    (!rstn && !power_on_rst && wr_start) |=> (write_error_flag && !wr_start &&
      $stable(memory_space_select) && $stable(config_space_select)))
    else $error("aborted write not flagged or selects lost");
  a_por_permit: assert property (
    (!rstn && power_on_rst) |=> (!write_permit && pwrt_cnt == 32'(PWRT_CYCLES)))
    else $error("power-on did not clear permit");

  // Main scenarios
  c_read: cover property (disable iff (!rstn) $rose(rd_start));
  c_eeprom_write: cover property (disable iff (!rstn) last_cycle && eeprom_target);
  c_flash_erase: cover property (disable iff (!rstn) last_cycle && row_erase);
  c_bad_attempt: cover property (disable iff (!rstn) $rose(write_error_flag));
  c_warm_abort: cover property (!rstn && !power_on_rst && wr_start);
endmodule

/* File: test/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dee_pkg::*;

  localparam int WC = 16;
  localparam int PW = 20;

  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic power_on_rst = 1'b1;
  logic [SEL_W-1:0] sfr_sel = SEL_CONTROL;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic eeprom_done_flag;
  logic nvm_busy;
  logic flash_op_active;
  int n_mismatch = 0;
  int comparisons = 0;

  always #2 mclk = ~mclk;

  dee_top #(.ADDR_W(8), .WRITE_CYCLES(WC), .PWRT_CYCLES(PW)) u_dut (
    .mclk(mclk),
    .rstn(rstn),
    .power_on_rst(power_on_rst),
    .sfr_sel(sfr_sel),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .eeprom_done_flag(eeprom_done_flag),
    .nvm_busy(nvm_busy),
    .flash_op_active(flash_op_active)
  );

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    sfr_sel = s;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
    @(negedge mclk);
  endtask

  // Data is sampled in the one cycle that it stands
  task automatic rd(input logic [2:0] s, input logic [7:0] exp, input string m);
    sfr_sel = s;
    sfr_rd = 1'b1;
    @(negedge mclk);
    chk(sfr_rdata, exp, m);
    sfr_rd = 1'b0;
    @(negedge mclk);
  endtask

  task automatic unlock_go(input logic [7:0] ctl);
    wr(SEL_UNLOCK, UNLOCK_KEY1);
    wr(SEL_UNLOCK, UNLOCK_KEY2);
    wr(SEL_CONTROL, ctl);
  endtask

  task automatic wait_idle(output int cnt);
    cnt = 0;
    while (nvm_busy === 1'b1) begin
      @(negedge mclk);
      cnt++;
      if (cnt > WC + 20) begin
        n_mismatch++;
        $display("mismatch at %0t: write never completed", $time);
        close_out();
      end
    end
  endtask

  task automatic do_reset(input logic por);
    rstn = 1'b0;
    power_on_rst = por;
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    power_on_rst = 1'b0;
  endtask

  task automatic t_power_up();
    // Writes are still locked out by the power-up timer here
    rd(SEL_CONTROL, 8'h00, "control after power-on");
    wr(SEL_CONTROL, 8'h04);
    unlock_go(8'h06);
    chk({7'h00, nvm_busy}, 8'h00, "write during power-up timer");
    rd(SEL_CONTROL, 8'h0C, "error flag after blocked write");
    rd(SEL_UNLOCK, 8'h00, "unlock port reads zero");
    repeat (PW + 5) @(negedge mclk);
    $display("test power_up done");
  endtask

  task automatic t_byte_write();
    int cnt;
    wr(SEL_ADDR, 8'h05);
    wr(SEL_DATA, 8'h3C);
    wr(SEL_CONTROL, 8'h04);
    unlock_go(8'h06);
    chk({7'h00, nvm_busy}, 8'h01, "write started");
    rd(SEL_CONTROL, 8'h06, "write start bit set while busy");
    wr(SEL_DATA, 8'h11);
    wr(SEL_ADDR, 8'h09);
    wr(SEL_CONTROL, 8'h84);
    wait_idle(cnt);
    // Nine busy cycles pass inside the calls since the start
    chk({7'h00, cnt == WC - 9}, 8'h01, "self-timed duration");
    chk({7'h00, eeprom_done_flag}, 8'h01, "done flag at completion");
    rd(SEL_CONTROL, 8'h04, "control after completion");
    rd(SEL_ADDR, 8'h05, "address held during write");
    rd(SEL_DATA, 8'h3C, "data held during write");
    wr(SEL_DATA, 8'h00);
    wr(SEL_CONTROL, 8'h05);
    rd(SEL_DATA, 8'h3C, "read back written byte");
    rd(SEL_CONTROL, 8'h04, "read start self-clears");
    rd(SEL_PFLAG2, 8'h10, "done flag kept until cleared");
    wr(SEL_PFLAG2, 8'h00);
    rd(SEL_PFLAG2, 8'h00, "done flag cleared by software");
    $display("test byte_write done");
  endtask

  task automatic t_bad_sequences();
    wr(SEL_UNLOCK, UNLOCK_KEY1);
    wr(SEL_DATA, 8'h77);
    wr(SEL_UNLOCK, UNLOCK_KEY2);
    wr(SEL_CONTROL, 8'h06);
    chk({7'h00, nvm_busy}, 8'h00, "broken unlock sequence");
    rd(SEL_CONTROL, 8'h0C, "error after broken sequence");
    wr(SEL_CONTROL, 8'h00);
    unlock_go(8'h06);
    chk({7'h00, nvm_busy}, 8'h00, "permit and start together");
    rd(SEL_CONTROL, 8'h0C, "error after same-write permit");
    wr(SEL_CONTROL, 8'h81);
    rd(SEL_DATA, 8'h77, "read refused in flash space");
    rd(SEL_CONTROL, 8'h80, "flash select kept");
    wr(SEL_CONTROL, 8'h41);
    rd(SEL_DATA, 8'h77, "read refused in config space");
    $display("test bad_sequences done");
  endtask

  task automatic t_flash_and_abort();
    int cnt;
    wr(SEL_CONTROL, 8'h94);
    unlock_go(8'h96);
    chk({7'h00, flash_op_active}, 8'h01, "flash row erase running");
    wait_idle(cnt);
    rd(SEL_CONTROL, 8'h84, "row erase enable cleared");
    unlock_go(8'h86);
    chk({7'h00, nvm_busy}, 8'h01, "flash write started");
    do_reset(1'b0);
    @(negedge mclk);
    chk({7'h00, nvm_busy}, 8'h00, "busy cleared by reset");
    rd(SEL_CONTROL, 8'h88, "control after warm reset");
    sfr_sel = SEL_CONTROL;
    sfr_rd = 1'b1;
    @(negedge mclk);
    chk(sfr_rdata & 8'hC8, 8'h88, "selects kept and error set");
    sfr_rd = 1'b0;
    @(negedge mclk);
    do_reset(1'b1);
    @(negedge mclk);
    rd(SEL_CONTROL, 8'h00, "power-on clears control");
    $display("test flash_and_abort done");
  endtask

  initial begin
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    power_on_rst = 1'b0;
    t_power_up();
    t_byte_write();
    t_bad_sequences();
    t_flash_and_abort();
    close_out();
  end

  initial begin
    #40000;
    n_mismatch++;
    $display("mismatch at %0t: run limit reached", $time);
    close_out();
  end
endmodule
